// ==== design/cssl_pkg.sv ====
`default_nettype none
package cssl_pkg;

	// system clock rate
	localparam int unsigned CLK_HZ = 20_000_000;

	// time after power-up before select pins may change, in milliseconds
	localparam int unsigned SETTLE_MS = 10;
	// quiet time after a select change while the new set loads, in ms
	localparam int unsigned RELOAD_MS = 1;
	// least times round down to whole cycles per ms (integer division)
	localparam int unsigned SETTLE_CYCLES = (SETTLE_MS * (CLK_HZ / 1000));
	localparam int unsigned RELOAD_CYCLES = (RELOAD_MS * (CLK_HZ / 1000));

	// cycles after reset release at which the strap level is caught
	localparam int unsigned STRAP_CAPTURE_CYCLES = 4;

	// counter width wide enough for the settle time
	localparam int unsigned CNT_W = 18;

	// number of stored configurations and select width
	localparam int unsigned NUM_CFG = 4;
	localparam int unsigned SEL_W = 2;

	// location and bit of the primary source control
	localparam logic [7:0] PRIM_SRC_LOC = 8'h13;
	localparam int unsigned PRIM_SRC_POS = 1;
	// location 0 bit holding the bus default flag
	localparam logic [7:0] BUS_FLAG_LOC = 8'h00;
	localparam int unsigned BUS_FLAG_POS = 7;

	// select value loaded when the strap chose the bus
	localparam logic [1:0] CFG_DEFAULT = 2'h0;

	// output state codes
	typedef enum logic [1:0] {
		CSSL_OUT_ACTIVE = 2'h0, // output toggling
		CSSL_OUT_TRI = 2'h1, // output high impedance
		CSSL_OUT_HOLD = 2'h2, // differential pair parked high/low
		CSSL_OUT_LOW = 2'h3 // single-ended output driven low
	} cssl_out_t;

endpackage
`default_nettype wire

// ==== design/cssl_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface cssl_if;
	logic strap_host_o; // board strap level from the host side
	logic strap_host_oe; // host strap pull present
	logic strap_dev_o; // device reference output on the strap pin
	logic strap_dev_oe; // device drives the strap pin
	logic strap_pin; // resolved strap pin level
	logic cfg_select_lo; // select pin 0 driven by host
	logic cfg_select_hi; // select pin 1 driven by host
	logic ref_source_select; // reference source select pin
	logic shutdown_enable_pin; // shutdown or output enable pin

	// device drive wins over the weak strap pull; nothing reads low
	assign strap_pin = strap_dev_oe ? strap_dev_o :
		(strap_host_oe ? strap_host_o : 1'b0);

	modport dev (
		input strap_pin,
		output strap_dev_o,
		output strap_dev_oe,
		input cfg_select_lo,
		input cfg_select_hi,
		input ref_source_select,
		input shutdown_enable_pin
	);

	modport host (
		output strap_host_o,
		output strap_host_oe,
		output cfg_select_lo,
		output cfg_select_hi,
		output ref_source_select,
		output shutdown_enable_pin
	);
endinterface
`default_nettype wire

// ==== design/cssl_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module cssl_host #(
	parameter int unsigned SETTLE_CYCLES = cssl_pkg::SETTLE_CYCLES,
	parameter int unsigned RELOAD_CYCLES = cssl_pkg::RELOAD_CYCLES
) (
	input wire logic clk_sys, // system clock
	input wire logic rst, // synchronous reset, active high
	cssl_if.host link, // pins toward the device
	input wire logic strap_pull_high, // board strap choice
	input wire logic bus_default_flag, // stored flag of location 0
	input wire logic [1:0] init_sel, // select levels held at power-up
	input wire logic req_valid, // request a new configuration
	input wire logic [1:0] req_sel, // configuration wanted
	input wire logic ref_sel_level, // level for the source select pin
	input wire logic sd_level, // level for the shutdown/enable pin
	output logic req_ready // request may be taken
);
	typedef enum logic [2:0] {
		HS_SETTLE = 3'b001, // power-up settle time
		HS_IDLE = 3'b010, // waiting for a request
		HS_GAP = 3'b100 // quiet time after a pin change
	} cssl_hstate_t;

	typedef struct packed {
		cssl_hstate_t state; // sequencer state
		logic [cssl_pkg::CNT_W-1:0] cnt; // settle and gap counter
		logic [1:0] sel; // select pin levels
		logic [1:0] target; // configuration being walked to
		logic ready; // request may be taken
		logic ref_sel; // source select pin level
		logic sd; // shutdown/enable pin level
		logic strap; // strap level held since power-up
	} cssl_hreg_t;

	cssl_hreg_t r;
	cssl_hreg_t next_r;
	logic allowed; // changes permitted by strap and flag

	// select levels only move with a high strap and a clear flag;
	// the strap is taken as held at power-up, a later pull change is moot
	assign allowed = r.strap & ~bus_default_flag;

	// next state of the host sequencer
	always_comb begin
		next_r = r;
		next_r.ref_sel = ref_sel_level;
		next_r.sd = sd_level;
		unique case (r.state)
			HS_SETTLE: begin
				// pins stay at their power-up level for the settle time
				if (r.cnt == cssl_pkg::CNT_W'(SETTLE_CYCLES - 1)) begin
					next_r.state = HS_IDLE;
					next_r.ready = allowed;
				end else begin
					next_r.cnt = r.cnt + 1'b1;
				end
			end
			HS_IDLE: begin
				next_r.ready = allowed;
				if (req_valid && r.ready && req_sel != r.sel) begin
					// one pin per step, the low pin first
					next_r.target = req_sel;
					if (req_sel[0] != r.sel[0]) begin
						next_r.sel[0] = req_sel[0];
					end else begin
						next_r.sel[1] = req_sel[1];
					end
					next_r.state = HS_GAP;
					next_r.cnt = '0;
					next_r.ready = 1'b0;
				end
			end
			HS_GAP: begin
				// leave the device alone while it reloads
				if (r.cnt == cssl_pkg::CNT_W'(RELOAD_CYCLES - 1)) begin
					next_r.cnt = '0;
					if (r.sel != r.target) begin
						next_r.sel[1] = r.target[1];
					end else begin
						next_r.state = HS_IDLE;
						next_r.ready = allowed;
					end
				end else begin
					next_r.cnt = r.cnt + 1'b1;
				end
			end
		endcase
	end

	// state register; select pins start at the tied level
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			r <= '{state: HS_SETTLE, cnt: '0, sel: init_sel, target: init_sel,
				ready: 1'b0, ref_sel: 1'b0, sd: 1'b0,
				strap: strap_pull_high};
		end else begin
			r <= next_r;
		end
	end

	assign link.strap_host_o = strap_pull_high;
	assign link.strap_host_oe = 1'b1;
	assign link.cfg_select_lo = r.sel[0];
	assign link.cfg_select_hi = r.sel[1];
	assign link.ref_source_select = r.ref_sel;
	assign link.shutdown_enable_pin = r.sd;
	assign req_ready = r.ready;
endmodule // cssl_host
`default_nettype wire

// ==== design/cssl_device.sv ====
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - strap level caught once at power-up, held
// - high strap: select pins; low: bus pins
// - after capture, strap pin drives reference clock, low in shutdown
// - load chosen set, or bus defaults by flag
// - low strap ignores select pins for loading
// - select pins tied or low; float reads low
// - host changes selects after 10ms, if permitted
// - host changes one select pin at a time
// - reload on change; host waits 1ms after
// - source select 0 crystal, 1 differential
// - primary source bit inverts source select
// - function bit high: shutdown, else enable
// - polarity bit sets enable level, default low
// - shutdown parks differential, single-ended low
// - disabled outputs tri-state or park per bits
module cssl_device #(
	parameter int unsigned NUM_OUT = 4,
	parameter int unsigned RELOAD_CYCLES = cssl_pkg::RELOAD_CYCLES
) (
	input wire logic clk_sys, // system clock
	input wire logic rst, // synchronous reset, active high
	cssl_if.dev link, // pins toward the host
	input wire logic refout_clk, // reference clock for the strap pin
	input wire logic bus_default_flag, // stored flag, location 0 bit 7
	input wire logic primary_source_bit, // stored primary source bit
	input wire logic pin_function_bit, // 1: pin is shutdown
	input wire logic pin_polarity_bit, // 1: enable active high
	input wire logic [NUM_OUT-1:0] out_stop_sel, // 0: tri-state
	input wire logic [NUM_OUT-1:0] out_ctrl_en, // 1: pin gates output
	input wire logic [NUM_OUT-1:0] out_single_ended, // 1: single-ended
	output logic load_pulse, // one-cycle load strobe
	output logic [1:0] load_cfg, // stored set to load
	output logic load_bus_defaults, // load bus defaults instead
	output logic bus_access_en, // shared pins are the bus
	output logic reload_busy, // a load is taking effect
	output logic strap_high, // caught strap level
	output logic use_diff_ref, // differential reference active
	output logic shutdown, // device powered down
	output logic [2*NUM_OUT-1:0] out_state // per output state code
);
	typedef enum logic [3:0] {
		DS_CAPTURE = 4'b0001, // waiting to catch the strap
		DS_LOAD = 4'b0010, // issuing a load
		DS_BUSY = 4'b0100, // load taking effect
		DS_RUN = 4'b1000 // watching the select pins
	} cssl_dstate_t;

	typedef struct packed {
		cssl_dstate_t state; // sequencer state
		logic [cssl_pkg::CNT_W-1:0] cnt; // capture and busy counter
		logic [1:0] sel_m; // select sync, first stage
		logic [1:0] sel_s; // select sync, second stage
		logic strap_m; // strap sync, first stage
		logic strap_s; // strap sync, second stage
		logic refsel_m; // source select sync, first stage
		logic refsel_s; // source select sync, second stage
		logic sdoe_m; // shutdown/enable sync, first stage
		logic sdoe_s; // shutdown/enable sync, second stage
		logic strap_high; // caught strap level
		logic [1:0] applied_sel; // select value last loaded
		logic load_pulse; // load strobe
		logic [1:0] load_cfg; // stored set to load
		logic load_bus_defaults; // bus defaults chosen
		logic bus_access_en; // shared pins are the bus
		logic reload_busy; // load in progress
		logic use_diff_ref; // differential reference active
		logic shutdown; // device powered down
		logic [2*NUM_OUT-1:0] out_state; // per output state code
		logic strap_o; // strap pin output level
		logic strap_oe; // strap pin driven
	} cssl_dreg_t;

	cssl_dreg_t r;
	cssl_dreg_t next_r;

	// next state of the loader and pin functions
	always_comb begin
		logic disabled;
		logic sd_now;
		disabled = 1'b0;
		sd_now = 1'b0;
		next_r = r;
		next_r.load_pulse = 1'b0;
		// two-stage synchronisers; an undriven pin resolves low
		next_r.sel_m = {link.cfg_select_hi, link.cfg_select_lo};
		next_r.sel_s = r.sel_m;
		next_r.strap_m = link.strap_pin;
		next_r.strap_s = r.strap_m;
		next_r.refsel_m = link.ref_source_select;
		next_r.refsel_s = r.refsel_m;
		next_r.sdoe_m = link.shutdown_enable_pin;
		next_r.sdoe_s = r.sdoe_m;

		unique case (r.state)
			DS_CAPTURE: begin
				// catch the strap once, a few cycles after release
				if (r.cnt ==
					cssl_pkg::CNT_W'(cssl_pkg::STRAP_CAPTURE_CYCLES - 1)) begin
					next_r.strap_high = r.strap_s;
					next_r.bus_access_en = ~r.strap_s;
					next_r.state = DS_LOAD;
					next_r.cnt = '0;
				end else begin
					next_r.cnt = r.cnt + 1'b1;
				end
			end
			DS_LOAD: begin
				next_r.load_pulse = 1'b1;
				next_r.reload_busy = 1'b1;
				next_r.applied_sel = r.sel_s;
				if (r.strap_high) begin
					// select pins choose the stored set, bus stays off
					next_r.load_cfg = r.sel_s;
					next_r.load_bus_defaults = 1'b0;
				end else begin
					// select pins play no part in the choice
					next_r.load_cfg = cssl_pkg::CFG_DEFAULT;
					next_r.load_bus_defaults = bus_default_flag;
				end
				next_r.state = DS_BUSY;
				next_r.cnt = '0;
			end
			DS_BUSY: begin
				// new set takes effect during the quiet time
				if (r.cnt == cssl_pkg::CNT_W'(RELOAD_CYCLES - 1)) begin
					next_r.reload_busy = 1'b0;
					next_r.state = DS_RUN;
					next_r.cnt = '0;
				end else begin
					next_r.cnt = r.cnt + 1'b1;
				end
			end
			DS_RUN: begin
				// reload only on a change, with strap high and flag clear
				if (r.strap_high && !bus_default_flag &&
					r.sel_s != r.applied_sel) begin
					next_r.state = DS_LOAD;
				end
			end
		endcase

		// source choice: pin level inverted by the primary source bit
		next_r.use_diff_ref = r.refsel_s ^ primary_source_bit;

		// pin is shutdown when the function bit is high
		if (pin_function_bit) begin
			sd_now = r.sdoe_s;
		end else begin
			// enable level follows the polarity bit, active low at 0
			disabled = (r.sdoe_s != pin_polarity_bit);
		end
		next_r.shutdown = sd_now;

		// per output state
		for (int i = 0; i < NUM_OUT; i++) begin
			if (sd_now) begin
				// parked pair, low single-ended output
				next_r.out_state[2*i +: 2] = out_single_ended[i] ?
					cssl_pkg::CSSL_OUT_LOW : cssl_pkg::CSSL_OUT_HOLD;
			end else if (!out_stop_sel[i]) begin
				next_r.out_state[2*i +: 2] = cssl_pkg::CSSL_OUT_TRI;
			end else if (out_ctrl_en[i] && disabled) begin
				next_r.out_state[2*i +: 2] = cssl_pkg::CSSL_OUT_HOLD;
			end else begin
				next_r.out_state[2*i +: 2] = cssl_pkg::CSSL_OUT_ACTIVE;
			end
		end

		// strap pin becomes the reference output once caught
		if (r.state != DS_CAPTURE) begin
			next_r.strap_oe = 1'b1;
			next_r.strap_o = sd_now ? 1'b0 : refout_clk;
		end
	end

	// state register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			r <= '0;
			r.state <= DS_CAPTURE;
		end else begin
			r <= next_r;
		end
	end

	assign link.strap_dev_o = r.strap_o;
	assign link.strap_dev_oe = r.strap_oe;
	assign load_pulse = r.load_pulse;
	assign load_cfg = r.load_cfg;
	assign load_bus_defaults = r.load_bus_defaults;
	assign bus_access_en = r.bus_access_en;
	assign reload_busy = r.reload_busy;
	assign strap_high = r.strap_high;
	assign use_diff_ref = r.use_diff_ref;
	assign shutdown = r.shutdown;
	assign out_state = r.out_state;
endmodule // cssl_device
`default_nettype wire

// ==== tb/cssl_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module cssl_monitor (
	input wire logic clk_sys, // clock
	input wire logic rst, // reset
	input wire logic strap_dev_oe, // strap pin driven
	input wire logic cfg_select_lo, // select 0
	input wire logic cfg_select_hi, // select 1
	input wire logic ref_source_select, // source pin
	input wire logic shutdown_enable_pin, // shutdown_enable_pin pin
	input wire logic bus_default_flag, // stored flag
	input wire logic primary_source_bit, // source invert
	input wire logic pin_function_bit, // pin is shutdown
	input wire logic load_pulse, // load strobe
	input wire logic [1:0] load_cfg, // set loaded
	input wire logic load_bus_defaults, // bus defaults
	input wire logic bus_access_en, // bus role
	input wire logic reload_busy, // load in effect
	input wire logic strap_high, // caught strap
	input wire logic use_diff_ref, // diff source
	input wire logic shutdown // powered down
);
	// every check runs on the system clock and rests in reset
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	strap_hold_a: assert property (
		strap_dev_oe && $past(strap_dev_oe) |-> $stable(strap_high))
		else $error("strap level moved after capture");
	pin_role_a: assert property (
		strap_dev_oe |-> bus_access_en == !strap_high)
		else $error("shared pin role disagrees with strap");
	refout_drive_a: assert property (
		$rose(strap_dev_oe) |-> load_pulse ##1 strap_dev_oe [*8])
		else $error("strap pin not driven after capture");
	sel_load_a: assert property (
		load_pulse && strap_high |-> !load_bus_defaults &&
		load_cfg == {cfg_select_hi, cfg_select_lo})
		else $error("wrong stored set loaded");
	bus_load_a: assert property (
		load_pulse && !strap_high |-> load_bus_defaults ==
		bus_default_flag && (bus_default_flag || load_cfg == 2'h0))
		else $error("wrong bus mode load");
	bus_ignore_a: assert property (
		!strap_high && strap_dev_oe && $past(strap_dev_oe) |-> !load_pulse)
		else $error("reload while strap chose the bus");
	reload_change_a: assert property (
		strap_high && !bus_default_flag && strap_dev_oe &&
		($changed(cfg_select_lo) || $changed(cfg_select_hi))
		|-> ##[1:40] load_pulse ##0 reload_busy)
		else $error("select change not reloaded");
	source_pick_a: assert property (
		($stable(ref_source_select) && $stable(primary_source_bit)) [*6]
		|-> use_diff_ref == (ref_source_select ^ primary_source_bit))
		else $error("wrong reference source");
	sd_map_a: assert property (
		($stable(shutdown_enable_pin) && $stable(pin_function_bit)) [*6]
		|-> shutdown == (pin_function_bit && shutdown_enable_pin))
		else $error("shutdown disagrees with pin");
endmodule // cssl_monitor
`default_nettype wire

// ==== tb/config_select_strap_loader_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module config_select_strap_loader_test;
	logic clk_sys = 1'b0; // system clock
	logic rst = 1'b1; // reset
	logic strap_pull_high = 1'b1; // strap choice
	logic bus_default_flag = 1'b0; // stored flag
	logic [1:0] init_sel = 2'h0; // power-up select
	logic req_valid = 1'b0; // select request
	logic [1:0] req_sel = 2'h0; // wanted set
	logic ref_sel_level = 1'b0; // source pin level
	logic sd_level = 1'b0; // shutdown_enable_pin pin level
	logic refout_clk = 1'b0; // clock for strap pin
	logic prim = 1'b0; // primary source bit
	logic func = 1'b0; // pin function bit
	logic pol = 1'b0; // pin polarity bit
	logic [3:0] stop = 4'hF; // stop selects
	logic [3:0] ctrl = 4'h0; // pin gating
	logic [3:0] se = 4'h0; // single-ended outputs
	logic req_ready, load_pulse, load_bus_defaults, bus_access_en; // status
	logic reload_busy, strap_high, use_diff_ref, shutdown; // status
	logic [1:0] load_cfg; // loaded set
	logic [7:0] out_state; // output codes
	logic [23:0] pin_case [5]; // function, pins, expected codes
	int fail_count = 0; // mismatches
	int tests_run = 0; // comparisons
	cssl_if link();

	cssl_host #(.SETTLE_CYCLES(16), .RELOAD_CYCLES(8)) i_cssl_host (
		.clk_sys(clk_sys), .rst(rst), .link(link),
		.strap_pull_high(strap_pull_high), .bus_default_flag(bus_default_flag),
		.init_sel(init_sel), .req_valid(req_valid), .req_sel(req_sel),
		.ref_sel_level(ref_sel_level), .sd_level(sd_level),
		.req_ready(req_ready));
	cssl_device #(.NUM_OUT(4), .RELOAD_CYCLES(8)) i_cssl_device (
		.clk_sys(clk_sys), .rst(rst), .link(link), .refout_clk(refout_clk),
		.bus_default_flag(bus_default_flag), .primary_source_bit(prim),
		.pin_function_bit(func), .pin_polarity_bit(pol),
		.out_stop_sel(stop), .out_ctrl_en(ctrl), .out_single_ended(se),
		.load_pulse(load_pulse), .load_cfg(load_cfg),
		.load_bus_defaults(load_bus_defaults), .bus_access_en(bus_access_en),
		.reload_busy(reload_busy), .strap_high(strap_high),
		.use_diff_ref(use_diff_ref), .shutdown(shutdown),
		.out_state(out_state));
	cssl_monitor i_cssl_monitor (
		.clk_sys(clk_sys), .rst(rst), .strap_dev_oe(link.strap_dev_oe),
		.cfg_select_lo(link.cfg_select_lo), .cfg_select_hi(link.cfg_select_hi),
		.ref_source_select(link.ref_source_select),
		.shutdown_enable_pin(link.shutdown_enable_pin),
		.bus_default_flag(bus_default_flag), .primary_source_bit(prim),
		.pin_function_bit(func), .load_pulse(load_pulse),
		.load_cfg(load_cfg), .load_bus_defaults(load_bus_defaults),
		.bus_access_en(bus_access_en), .reload_busy(reload_busy),
		.strap_high(strap_high), .use_diff_ref(use_diff_ref),
		.shutdown(shutdown));

	// clock and the reference clock sent out on the strap pin
	always #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys) refout_clk <= ~refout_clk;

	// compare and count
	task check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// verdict and end of run
	task end_sim;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// wait for the next load strobe; exp is {bus defaults, set}
	task wait_pulse(input logic [2:0] exp);
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			#1;
			n++;
		end while (load_pulse !== 1'b1 && n < 60);
		check({4'h0, load_pulse, load_bus_defaults, load_cfg},
			{4'h0, 1'b1, exp});
	endtask

	// power-up with a strap, flag and select levels
	task boot(input logic strap, flag, input logic [1:0] sel, exp);
		@(posedge clk_sys);
		rst <= 1'b1;
		strap_pull_high <= strap;
		bus_default_flag <= flag;
		init_sel <= sel;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		wait_pulse({~strap & flag, exp});
		check({bus_access_en, link.strap_dev_oe}, {~strap, 1'b1});
	endtask

	// ask the host for a new set once it is ready
	task request(input logic [1:0] sel);
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (req_ready !== 1'b1 && n < 100);
		req_valid <= 1'b1;
		req_sel <= sel;
		@(posedge clk_sys);
		req_valid <= 1'b0;
	endtask

	// main sequence
	initial begin
		pin_case = '{24'hBF05BB, 24'h2EB089, 24'h0EB001, 24'h4EB089, 24'h8F0500};
		for (int i = 0; i < 4; i++) begin
			boot(1'b1, 1'b0, i[1:0], i[1:0]);
		end
		boot(1'b0, 1'b1, 2'h0, 2'h0);
		boot(1'b0, 1'b0, 2'h2, 2'h0);
		repeat (60) @(posedge clk_sys);
		check(req_ready, 1'b0);
		boot(1'b1, 1'b1, 2'h1, 2'h1);
		repeat (60) @(posedge clk_sys);
		check(req_ready, 1'b0);
		boot(1'b1, 1'b0, 2'h0, 2'h0);
		// pull the strap low after capture: both ends must hold high
		@(posedge clk_sys);
		strap_pull_high <= 1'b0;
		request(2'h3);
		wait_pulse(3'h1);
		wait_pulse(3'h3);
		// pin shows the reference clock one edge late, not the low pull
		check({strap_high, link.strap_pin}, {1'b1, ~refout_clk});
		request(2'h2);
		wait_pulse(3'h2);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			prim <= i[1];
			ref_sel_level <= i[0];
			repeat (6) @(posedge clk_sys);
			#1;
			check(use_diff_ref, i[1] ^ i[0]);
		end
		for (int i = 0; i < 5; i++) begin
			@(posedge clk_sys);
			{func, pol, sd_level} <= pin_case[i][23:21];
			{stop, ctrl, se} <= pin_case[i][19:8];
			repeat (6) @(posedge clk_sys);
			#1;
			check(out_state, pin_case[i][7:0]);
			check(shutdown, pin_case[i][20]);
		end
		end_sim;
	end

	// cut a hang short
	initial begin
		repeat (5000) @(posedge clk_sys);
		fail_count++;
		end_sim;
	end
endmodule // config_select_strap_loader_test
`default_nettype wire
